// File: design/tag_alarm_chan.sv
`timescale 1ns/1ps
`include "tag_params.svh"

module tag_alarm_chan #(
	parameter int CNT_W   = 32,
	parameter int PULSE_W = 16
) (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  pce,
	// selected timer count
	input  wire logic [CNT_W-1:0]      count,
	// commands and stored settings
	input  wire tag_pkg::tag_chan_cmd_t cmd,
	input  wire tag_pkg::tag_chan_cfg_t cfg,
	input  wire logic [CNT_W-1:0]      trig_stored,
	input  wire logic [PULSE_W-1:0]    pulse_stored,
	// state and events
	output logic                       run_r,
	output logic                       alarm_r,
	output logic                       fire,
	output logic [PULSE_W-1:0]         fire_len,
	output logic                       upd_done
);

	logic [CNT_W-1:0]   act_trig_r;
	logic [PULSE_W-1:0] act_pulse_r;
	logic [CNT_W-1:0]   ref_r;
	logic               first_r;
	logic               cond_q_r;
	logic [CNT_W-1:0]   delta;
	logic               cond;

	// match condition per mode; reserved code never triggers
	always_comb begin
		delta = CNT_W'(count - ref_r);
		unique case (cfg.mode)
			`TAG_MODE_ABS:  cond = (count == act_trig_r);
			`TAG_MODE_REL:  cond = (delta == act_trig_r);
			`TAG_MODE_COMB: cond = first_r ? (count == act_trig_r)
			                               : (delta == act_trig_r);
			default:        cond = 1'b0;
		endcase
	end

	// only the first cycle of a match fires, so a slow timer that holds a count
	// does not raise a burst of alarms
	assign fire     = run_r & cond & ~cond_q_r & ~cmd.arm & ~cmd.halt;
	assign upd_done = fire & cfg.pend;
	assign fire_len = upd_done ? pulse_stored : act_pulse_r;

	// running flag: halt wins over arm, single mode stops after one trigger
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r <= 1'b0;
		end else if (pce) begin
			if (cmd.halt) begin
				run_r <= 1'b0;
			end else if (cmd.arm) begin
				run_r <= 1'b1;
			end else if (fire && !cfg.repeat_en) begin
				run_r <= 1'b0;
			end
		end
	end

	// active settings change only at arm or at a trigger with an update pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_trig_r  <= '0;
			act_pulse_r <= '0;
		end else if (pce && !cmd.halt && (cmd.arm || upd_done)) begin
			act_trig_r  <= trig_stored;
			act_pulse_r <= pulse_stored;
		end
	end

	// reference count: taken at arm, then at every trigger for the next increment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_r   <= '0;
			first_r <= 1'b1;
		end else if (pce) begin
			if (cmd.arm) begin
				ref_r   <= count;
				first_r <= 1'b1;
			end else if (fire) begin
				ref_r   <= count;
				first_r <= 1'b0;
			end
		end
	end

	// alarm output is a one-cycle pulse per trigger
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_q_r <= 1'b0;
			alarm_r  <= 1'b0;
		end else if (pce) begin
			cond_q_r <= run_r & cond;
			alarm_r  <= fire;
		end
	end

	sequence s_arm;
		pce && cmd.arm && !cmd.halt;
	endsequence

	sequence s_fire_upd;
		pce && fire && cfg.pend;
	endsequence

	AST_HALT_STOPS: assert property (@(posedge pclk) disable iff (!presetn)
		pce && cmd.halt |=> !run_r)
		else $error("halt did not stop the channel");

	AST_ARM_LOADS: assert property (@(posedge pclk) disable iff (!presetn)
		s_arm |=> run_r && act_trig_r == $past(trig_stored) && act_pulse_r == $past(pulse_stored))
		else $error("arm did not start and load the channel");

	AST_HOLD_WHILE_RUN: assert property (@(posedge pclk) disable iff (!presetn)
		run_r && !cmd.arm && !fire |=> $stable(act_trig_r) && $stable(act_pulse_r))
		else $error("active settings changed without a trigger");

	AST_UPD_AT_FIRE: assert property (@(posedge pclk) disable iff (!presetn)
		s_fire_upd |=> act_trig_r == $past(trig_stored))
		else $error("pending update not applied at trigger");

	AST_SINGLE_STOPS: assert property (@(posedge pclk) disable iff (!presetn)
		pce && fire && !cfg.repeat_en |=> !run_r ##1 !alarm_r)
		else $error("single mode channel kept running");

	AST_CONT_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
		pce && fire && cfg.repeat_en |=> run_r && ref_r == $past(count))
		else $error("continuous channel lost its run or reference");

	AST_ALARM_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
		alarm_r |-> $past(run_r))
		else $error("alarm raised by a stopped channel");

	AST_REL_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		pce && fire && cfg.mode == `TAG_MODE_REL |-> delta == act_trig_r)
		else $error("relative trigger at wrong increment");

endmodule

// File: design/tag_alarm_top.sv
`timescale 1ns/1ps
`include "tag_params.svh"


module tag_alarm_top #(
	parameter int NCH     = 4,
	parameter int CNT_W   = 32,
	parameter int PULSE_W = 16
) (
	// clock, reset, enable
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    pce,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`TAG_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	// timer counts, same clock domain
	input  wire logic [CNT_W-1:0]        timer1_count,
	input  wire logic [CNT_W-1:0]        timer2_count,
	// alarm outputs
	output logic [NCH-1:0]               alarm,
	output logic [NCH-1:0]               irq_event,
	output logic [NCH-1:0]               gpio_pulse
);

	logic                         count_source_select_r;
	tag_pkg::tag_chan_cfg_t       cfg_r   [NCH];
	logic [CNT_W-1:0]             trig_r  [NCH];
	logic [PULSE_W-1:0]           pulse_r [NCH];
	logic [31:0]                  prdata_r;
	logic                         pready_r;
	logic                         pslverr_r;
	logic [NCH-1:0]               alarm_d_r;
	logic [NCH-1:0]               irq_r;
	logic [NCH-1:0]               run;
	logic [NCH-1:0]               alm;
	logic [NCH-1:0]               fire;
	logic [NCH-1:0]               upd_done;
	logic [NCH-1:0]               gpio;
	logic [PULSE_W-1:0]           fire_len [NCH];
	tag_pkg::tag_chan_cmd_t       cmd      [NCH];
	logic [CNT_W-1:0]             sel_count;
	logic                         setup;
	logic                         wr;
	logic                         is_src;
	logic                         is_cmd;
	logic                         is_stat;
	logic                         is_ch;
	logic [1:0]                   ch_idx;
	logic [1:0]                   ch_wrd;
	logic [31:0]                  rdata;

	// apb phase decode; the access completes in its first cycle when pce is high in its setup cycle
	assign setup   = psel & ~penable;
	assign wr      = psel & penable & pready_r & pwrite;
	assign ch_idx  = paddr[`TAG_CH_IDX_HI:`TAG_CH_IDX_LO];
	assign ch_wrd  = paddr[`TAG_CH_WRD_HI:`TAG_CH_WRD_LO];
	assign is_src  = (paddr == `TAG_OFF_SRC);
	assign is_cmd  = (paddr == `TAG_OFF_CMD);
	assign is_stat = (paddr == `TAG_OFF_STAT);
	assign is_ch   = (paddr[`TAG_CH_REG_HI:`TAG_CH_REG_LO] == `TAG_CH_REGION)
	               && (ch_wrd != 2'h3) && (int'(ch_idx) < NCH) && (paddr[1:0] == 2'h0);

	// one source feeds every channel
	assign sel_count = (count_source_select_r == `TAG_SRC_TIMER2) ? timer2_count : timer1_count;

	// read mux; reserved bits read zero
	always_comb begin
		rdata = `TAG_RST_WORD;
		if (is_src) begin
			rdata[0] = count_source_select_r;
		end else if (is_stat) begin
			rdata[`TAG_STAT_RUN_LSB +: NCH]  = run;
			rdata[`TAG_STAT_ALM_LSB +: NCH]  = alm;
			rdata[`TAG_STAT_GPIO_LSB +: NCH] = gpio;
		end else if (is_ch) begin
			unique case (ch_wrd)
				`TAG_WRD_CFG: begin
					rdata[`TAG_CFG_REP_BIT]        = cfg_r[ch_idx].repeat_en;
					rdata[`TAG_CFG_MODE_LSB +: 2]  = cfg_r[ch_idx].mode;
					rdata[`TAG_CFG_PEND_BIT]       = cfg_r[ch_idx].pend;
				end
				`TAG_WRD_TRIG:  rdata[CNT_W-1:0]   = trig_r[ch_idx];
				`TAG_WRD_PULSE: rdata[PULSE_W-1:0] = pulse_r[ch_idx];
				default:        rdata              = `TAG_RST_WORD;
			endcase
		end
	end

	// apb answer: ready, error and read data all launched from the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= `TAG_RST_WORD;
		end else if (pce) begin
			pready_r  <= setup;
			pslverr_r <= setup & ~(is_src | is_cmd | is_stat | is_ch);
			prdata_r  <= (setup & ~pwrite) ? rdata : `TAG_RST_WORD;
		end
	end

	// source select; software keeps it steady while any channel runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_source_select_r <= `TAG_SRC_TIMER1;
		end else if (pce && wr && is_src) begin
			count_source_select_r <= pwdata[0];
		end
	end

	// per channel: stored settings, command decode, channel and pin pulse
	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			logic wr_ch;
			assign wr_ch = wr && is_ch && (ch_idx == 2'(i));
			assign cmd[i].arm  = wr && is_cmd && pwdata[`TAG_CMD_ARM_LSB + i];
			assign cmd[i].halt = wr && is_cmd && pwdata[`TAG_CMD_HALT_LSB + i];

			// stored values are always writable; the channel decides when to use them
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					trig_r[i]  <= '0;
					pulse_r[i] <= '0;
				end else if (pce && wr_ch) begin
					if (ch_wrd == `TAG_WRD_TRIG) begin
						trig_r[i] <= pwdata[CNT_W-1:0];
					end
					if (ch_wrd == `TAG_WRD_PULSE) begin
						pulse_r[i] <= pwdata[PULSE_W-1:0];
					end
				end
			end

			// pending update: a software set in the same cycle beats the hardware clear
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_r[i] <= '0;
				end else if (pce) begin
					if (wr_ch && ch_wrd == `TAG_WRD_CFG) begin
						cfg_r[i].repeat_en <= pwdata[`TAG_CFG_REP_BIT];
						cfg_r[i].mode      <= pwdata[`TAG_CFG_MODE_LSB +: 2];
						cfg_r[i].pend      <= pwdata[`TAG_CFG_PEND_BIT];
					end else if (upd_done[i]) begin
						cfg_r[i].pend <= 1'b0;
					end
				end
			end

			tag_alarm_chan #(
				.CNT_W   (CNT_W),
				.PULSE_W (PULSE_W)
			) u_chan (
				.pclk         (pclk),
				.presetn      (presetn),
				.pce          (pce),
				.count        (sel_count),
				.cmd          (cmd[i]),
				.cfg          (cfg_r[i]),
				.trig_stored  (trig_r[i]),
				.pulse_stored (pulse_r[i]),
				.run_r        (run[i]),
				.alarm_r      (alm[i]),
				.fire         (fire[i]),
				.fire_len     (fire_len[i]),
				.upd_done     (upd_done[i])
			);

			tag_pulse_gen #(
				.PULSE_W (PULSE_W)
			) u_pulse (
				.pclk    (pclk),
				.presetn (presetn),
				.pce     (pce),
				.start   (fire[i]),
				.len     (fire_len[i]),
				.gpio_r  (gpio[i])
			);
		end
	endgenerate

	// interrupt event on each rising edge of an alarm output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_d_r <= '0;
			irq_r     <= '0;
		end else if (pce) begin
			alarm_d_r <= alm;
			irq_r     <= alm & ~alarm_d_r;
		end
	end

	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign alarm      = alm;
	assign irq_event  = irq_r;
	assign gpio_pulse = gpio;

	AST_IRQ_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
		pce && (alm[0] && !alarm_d_r[0]) |=> irq_r[0])
		else $error("alarm rise gave no interrupt event");

	AST_IRQ_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
		pce && |irq_r |-> $past(|alm))
		else $error("interrupt event without an alarm");

	AST_SRC_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
		pce && wr && is_src && pwdata[0] |=> sel_count == timer2_count)
		else $error("source select did not pick timer two");

	AST_APB_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		pce && setup |=> pready_r)
		else $error("apb access not answered in its first cycle");

endmodule

// File: design/tag_params.svh
`ifndef TAG_PARAMS_SVH
`define TAG_PARAMS_SVH

// apb byte offsets
`define TAG_ADDR_W        12
`define TAG_OFF_SRC       12'h000
`define TAG_OFF_CMD       12'h004
`define TAG_OFF_STAT      12'h008
// channel blocks: 0x040 + 0x010 * channel, word index in bits 3:2
`define TAG_CH_REGION     6'h01
`define TAG_CH_REG_HI     11
`define TAG_CH_REG_LO     6
`define TAG_CH_IDX_HI     5
`define TAG_CH_IDX_LO     4
`define TAG_CH_WRD_HI     3
`define TAG_CH_WRD_LO     2
`define TAG_WRD_CFG       2'h0
`define TAG_WRD_TRIG      2'h1
`define TAG_WRD_PULSE     2'h2

// command word fields
`define TAG_CMD_ARM_LSB   0
`define TAG_CMD_HALT_LSB  4
// status word fields
`define TAG_STAT_RUN_LSB  0
`define TAG_STAT_ALM_LSB  4
`define TAG_STAT_GPIO_LSB 8
// channel config word fields
`define TAG_CFG_REP_BIT   0
`define TAG_CFG_MODE_LSB  1
`define TAG_CFG_PEND_BIT  3

// trigger mode codes
`define TAG_MODE_ABS      2'h0
`define TAG_MODE_REL      2'h1
`define TAG_MODE_COMB     2'h2

// source select codes
`define TAG_SRC_TIMER1    1'b0
`define TAG_SRC_TIMER2    1'b1

// reset values
`define TAG_RST_WORD      32'h0000_0000

`endif

// File: design/tag_pkg.sv
package tag_pkg;

	// per-channel configuration carried from the register file to a channel
	typedef struct packed {
		logic       pend;
		logic [1:0] mode;
		logic       repeat_en;
	} tag_chan_cfg_t;

	// per-channel one-cycle commands
	typedef struct packed {
		logic arm;
		logic halt;
	} tag_chan_cmd_t;

endpackage

// File: design/tag_pulse_gen.sv
`timescale 1ns/1ps
`include "tag_params.svh"

module tag_pulse_gen #(
	parameter int PULSE_W = 16
) (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               pce,
	// start request
	input  wire logic               start,
	input  wire logic [PULSE_W-1:0] len,
	// pin level
	output logic                    gpio_r
);

	logic [PULSE_W-1:0] left_r;

	// a new trigger restarts the pulse; a zero length gives no pulse at all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_r <= '0;
			gpio_r <= 1'b0;
		end else if (pce) begin
			if (start) begin
				left_r <= len;
				gpio_r <= (len != '0);
			end else if (left_r != '0) begin
				left_r <= PULSE_W'(left_r - 1'b1);
				gpio_r <= (left_r != PULSE_W'(1));
			end
		end
	end

	AST_PULSE_START: assert property (@(posedge pclk) disable iff (!presetn)
		pce && start && len != '0 |=> gpio_r && left_r == $past(len))
		else $error("pulse did not start with the loaded length");

	AST_PULSE_END: assert property (@(posedge pclk) disable iff (!presetn)
		pce && !start && left_r == PULSE_W'(1) |=> !gpio_r && left_r == '0)
		else $error("pulse did not end after its length");

endmodule

// File: testbench/tag_timer_model.sv
`timescale 1ns/1ps

// stands in for the two general-purpose timers that feed the alarm block
module tag_timer_model #(
	parameter int unsigned START2 = 32'h0000_1000,
	parameter int unsigned LIMIT  = 32'h0000_FFFF
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// low holds the first timer, to play a slow source
	input  wire logic        run1,
	// count values
	output logic      [31:0] count1,
	output logic      [31:0] count2
);
	// count2 counts up without pause, count1 only while run1 is high; both wrap past a limit set above every trigger value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count1 <= '0;
			count2 <= START2;
		end else begin
			if (run1)
				count1 <= (count1 == LIMIT) ? '0 : count1 + 1'b1;
			count2 <= (count2 == LIMIT) ? '0 : count2 + 1'b1;
		end
	end
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps

module testbench;
	// one register access: optional write, then a read and its expected answer
	typedef struct {
		bit          wr;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic        err;
	} tag_row_t;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        run1 = 1'b1;
	logic        pce = 1'b1;
	logic        src = 1'b0;
	logic [31:0] t1;
	logic [31:0] t2;
	logic [3:0]  alarm;
	logic [3:0]  irq_event;
	logic [3:0]  gpio_pulse;
	logic [3:0]  pa = '0;
	logic [31:0] prv = '0;
	logic [31:0] take;
	logic [31:0] q;
	logic        e;
	logic [31:0] x;
	logic [31:0] hitq[4][$];
	int          glen[4][$];
	int          gcnt[4] = '{default: 0};
	int          n_fail = 0;
	int          checks = 0;
	tag_row_t    rows[10];

	always #25 pclk = ~pclk;

	tag_timer_model tag_timer_model_i (
		.pclk(pclk), .presetn(presetn), .run1(run1), .count1(t1), .count2(t2)
	);

	tag_alarm_top tag_alarm_top_i (
		.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer1_count(t1), .timer2_count(t2), .alarm(alarm), .irq_event(irq_event), .gpio_pulse(gpio_pulse)
	);

	// one comparison; a mismatch is reported at once and counted
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("mismatches %0d of %0d comparisons", n_fail, checks);
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// whole apb transfer held until pready; take keeps the selected count at the acting edge
	task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		take = src ? t2 : t1;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// read with a mask, since alarm and gpio bits of the status word move on their own
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] xp);
		apb(1'b0, a, '0);
		chk(q & m, xp);
	endtask

	// waits for the k-th trigger of a channel and checks the count it fired on
	task automatic hit(input int ch, input int k, input logic [31:0] xp);
		while (hitq[ch].size() <= k)
			@(posedge pclk);
		chk(hitq[ch][k], xp);
	endtask

	task automatic plen(input int ch, input int k, input int xp);
		while (glen[ch].size() <= k)
			@(posedge pclk);
		chk(32'(glen[ch][k]), 32'(xp));
	endtask

	function automatic logic [11:0] ca(input int ch, input int w);
		return 12'h040 + 12'(16 * ch + 4 * w);
	endfunction

	// trigger counts are the count of the cycle before alarm; pulse lengths counted at the fall
	always @(posedge pclk) begin
		for (int i = 0; i < 4; i++) begin
			// a frozen block holds its event output, so only live cycles are compared
			if (presetn === 1'b1 && pce === 1'b1 && (irq_event[i] === 1'b1 || pa[i] === 1'b1))
				chk(32'(irq_event[i]), 32'(pa[i]));
			if (alarm[i] === 1'b1)
				hitq[i].push_back(prv);
			if (gpio_pulse[i] === 1'b1)
				gcnt[i]++;
			else if (gcnt[i] != 0) begin
				glen[i].push_back(gcnt[i]);
				gcnt[i] = 0;
			end
		end
		pa  = alarm;
		prv = src ? t2 : t1;
	end

	// a hang is cut short well after the roughly 400 cycles the sequence needs
	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		$display("wrong value at %0t: timeout", $time);
		tally_and_finish();
	end

	initial begin
		rows[0] = '{1'b0, 12'h000, '0, '0, 1'b0};
		rows[1] = '{1'b0, 12'h008, '0, '0, 1'b0};
		rows[2] = '{1'b0, ca(0, 0), '0, '0, 1'b0};
		rows[3] = '{1'b1, 12'h004, '0, '0, 1'b0};
		rows[4] = '{1'b1, ca(1, 1), 32'h1234_5678, 32'h1234_5678, 1'b0};
		rows[5] = '{1'b1, ca(2, 2), 32'hFFFF_ABCD, 32'h0000_ABCD, 1'b0};
		rows[6] = '{1'b1, ca(3, 0), 32'h0000_0007, 32'h0000_0007, 1'b0};
		rows[7] = '{1'b1, 12'h04C, 32'h0000_0001, '0, 1'b1};
		rows[8] = '{1'b1, 12'h000, 32'hFFFF_FFFF, 32'h0000_0001, 1'b0};
		rows[9] = '{1'b1, 12'h000, '0, '0, 1'b0};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				apb(1'b1, rows[i].a, rows[i].d);
				chk(32'(e), 32'(rows[i].err));
			end
			apb(1'b0, rows[i].a, '0);
			chk(q, rows[i].e);
			chk(32'(e), 32'(rows[i].err));
		end
		// absolute single shot, with the timer stalled on its way to the match
		x = take + 32'h0000_0028;
		apb(1'b1, ca(0, 1), x);
		apb(1'b1, ca(0, 0), '0);
		apb(1'b1, ca(0, 2), 32'h0000_0004);
		apb(1'b1, 12'h004, 32'h0000_0001);
		rd(12'h008, 32'h0000_000F, 32'h0000_0001);
		run1 <= 1'b0;
		repeat (5) @(posedge pclk);
		run1 <= 1'b1;
		hit(0, 0, x);
		plen(0, 0, 4);
		repeat (10) @(posedge pclk);
		chk(32'(hitq[0].size()), 32'h0000_0001);
		rd(12'h008, 32'h0000_000F, '0);
		// relative continuous, then deferred updates without and with the pending bit
		apb(1'b1, ca(1, 0), 32'h0000_0003);
		apb(1'b1, ca(1, 1), 32'h0000_0014);
		apb(1'b1, ca(1, 2), 32'h0000_0002);
		apb(1'b1, 12'h004, 32'h0000_0002);
		x = take;
		hit(1, 0, x + 32'h0000_0014);
		apb(1'b1, ca(1, 1), 32'h0000_0005);
		apb(1'b1, ca(1, 2), 32'h0000_0003);
		hit(1, 1, x + 32'h0000_0028);
		plen(1, 1, 2);
		apb(1'b1, ca(1, 0), 32'h0000_000B);
		hit(1, 2, x + 32'h0000_003C);
		plen(1, 2, 3);
		hit(1, 3, x + 32'h0000_0041);
		rd(ca(1, 0), 32'hFFFF_FFFF, 32'h0000_0003);
		rd(12'h008, 32'h0000_000F, 32'h0000_0002);
		// re-arm while running loads the stored value and restarts the reference
		apb(1'b1, ca(1, 1), 32'h0000_000C);
		apb(1'b1, 12'h004, 32'h0000_0002);
		x = take;
		hitq[1].delete();
		hit(1, 0, x + 32'h0000_000C);
		apb(1'b1, 12'h004, 32'h0000_0020);
		hitq[1].delete();
		repeat (30) @(posedge pclk);
		chk(32'(hitq[1].size()), '0);
		// combination mode on the second timer, stepping by an update applied at the first match
		apb(1'b1, 12'h000, 32'h0000_0001);
		src = 1'b1;
		x = t2 + 32'h0000_0028;
		apb(1'b1, ca(2, 1), x);
		apb(1'b1, ca(2, 2), 32'h0000_0001);
		apb(1'b1, ca(2, 0), 32'h0000_0005);
		apb(1'b1, 12'h004, 32'h0000_0004);
		apb(1'b1, ca(2, 1), 32'h0000_0007);
		apb(1'b1, ca(2, 0), 32'h0000_000D);
		hit(2, 0, x);
		hit(2, 1, x + 32'h0000_0007);
		hit(2, 2, x + 32'h0000_000E);
		apb(1'b1, 12'h004, 32'h0000_0040);
		apb(1'b1, 12'h000, '0);
		src = 1'b0;
		// reserved mode never fires; halt beats arm in one write
		apb(1'b1, ca(3, 1), take + 32'h0000_0008);
		apb(1'b1, ca(3, 0), 32'h0000_0006);
		apb(1'b1, 12'h004, 32'h0000_0008);
		repeat (40) @(posedge pclk);
		chk(32'(hitq[3].size()), '0);
		apb(1'b1, 12'h004, 32'h0000_0088);
		rd(12'h008, 32'h0000_000F, '0);
		// reset in mid-run clears every output and register
		apb(1'b1, ca(0, 0), 32'h0000_0003);
		apb(1'b1, ca(0, 1), 32'h0000_0003);
		apb(1'b1, 12'h004, 32'h0000_0001);
		hit(0, 1, take + 32'h0000_0003);
		// clock enable low freezes the channel: no further triggers while it is low
		pce <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(32'(hitq[0].size()), 32'h0000_0002);
		presetn <= 1'b0;
		@(posedge pclk);
		chk(32'({alarm, irq_event, gpio_pulse}), '0);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		pce     <= 1'b1;
		@(posedge pclk);
		rd(12'h008, 32'hFFFF_FFFF, '0);
		rd(ca(0, 1), 32'hFFFF_FFFF, '0);
		tally_and_finish();
	end
endmodule
